// File: hw/rtcc_ctrl.v
// Notes on behaviour
// - Value register writes only while write-enable set
// - Ripple flag high while reads may tear
// - Half-second bit shows current half of second
// - Half-second read-only, cleared by seconds write
// - Clock output driven only while output-enable set
// - On bit writes ignored without write-enable
// - Write-enable set only while unlock active
// - Control register cleared only by power-on reset
//
// The Wishbone slave port and the address map were decided locally.
`timescale 1ns/1ps
`include "rtcc_regs.vh"

module rtcc_ctrl #(
  parameter [31:0] HALF_SEC_CYC = `RTCC_HALF_SEC_CYC
)
(
  input wire CORE_CLK,
  input wire SYS_RST,
  input wire WARM_RST,
  input wire UNLOCK,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [3:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  output wire [31:0] WB_DAT_O,
  output wire WB_ACK_O,
  output wire RTCC_OUT,
  output wire RTCC_OUT_OE
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_MIN = 3'b010;
  localparam [2:0] ST_HOUR = 3'b100;
  localparam [31:0] CTRL_RST = `RTCC_CTRL_RST;

  reg ack_ff;
  reg [31:0] dat_ff;
  reg on_ff;
  reg wren_ff;
  reg oe_ff;
  reg sync_ff;
  reg [6:0] sec_ff;
  reg [6:0] min_ff;
  reg [6:0] hour_ff;
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg out_ff;
  reg out_oe_ff;
  reg [6:0] nxt_sec;
  reg [6:0] nxt_min;
  reg [6:0] nxt_hour;

  wire phase;
  wire sec_pulse;
  wire near_roll;

  wire req = WB_CYC_I & WB_STB_I & ~ack_ff;
  // Writes commit at the edge where the master sees the acknowledge
  wire wr = WB_CYC_I & WB_STB_I & ack_ff & WB_WE_I;
  wire hit_ctrl = (WB_ADR_I == `RTCC_CTRL_ADDR);
  wire hit_time = (WB_ADR_I == `RTCC_TIME_ADDR);
  wire wr_ctrl = wr & hit_ctrl;
  wire wr_time = wr & hit_time & wren_ff;
  wire wr_sec = wr_time & WB_SEL_I[1];

  function [6:0] wrap_inc;
    input [6:0] v;
    input [6:0] max;
    begin
      if (v >= max)
        wrap_inc = 7'h00;
      else
        wrap_inc = v + 7'h01;
    end
  endfunction

  function [31:0] ctrl_word;
    input on;
    input wren;
    input sync;
    input half;
    input oe;
    begin
      ctrl_word = 32'h00000000;
      ctrl_word[`RTCC_ON_BIT] = on;
      ctrl_word[`RTCC_WREN_BIT] = wren;
      ctrl_word[`RTCC_SYNC_BIT] = sync;
      ctrl_word[`RTCC_HALF_BIT] = half;
      ctrl_word[`RTCC_OE_BIT] = oe;
    end
  endfunction

  rtcc_tick #(
    .HALF_CYC(HALF_SEC_CYC)
  ) u_tick (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .run(on_ff),
    .restart(wr_sec),
    .phase(phase),
    .sec_pulse(sec_pulse),
    .near_roll(near_roll)
  );

  // Bus response; warm reset only drops a pending answer
  always @(posedge CORE_CLK)
  begin
    if (SYS_RST | WARM_RST)
    begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h00000000;
    end
    else
    begin
      ack_ff <= req;
      if (req & ~WB_WE_I)
      begin
        if (hit_ctrl)
          dat_ff <= ctrl_word(on_ff, wren_ff, sync_ff, phase, oe_ff);
        else if (hit_time)
        begin
          dat_ff <= 32'h00000000;
          dat_ff[`RTCC_SEC_MSB:`RTCC_SEC_LSB] <= sec_ff;
          dat_ff[`RTCC_MIN_MSB:`RTCC_MIN_LSB] <= min_ff;
          dat_ff[`RTCC_HOUR_MSB:`RTCC_HOUR_LSB] <= hour_ff;
        end
        else
          dat_ff <= 32'h00000000;
      end
    end
  end

  // Control bits: only the power-on reset clears them
  always @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      on_ff <= CTRL_RST[`RTCC_ON_BIT];
      wren_ff <= CTRL_RST[`RTCC_WREN_BIT];
      oe_ff <= CTRL_RST[`RTCC_OE_BIT];
    end
    else if (wr_ctrl)
    begin
      if (WB_SEL_I[1] & wren_ff)
        on_ff <= WB_DAT_I[`RTCC_ON_BIT];
      if (WB_SEL_I[0])
      begin
        oe_ff <= WB_DAT_I[`RTCC_OE_BIT];
        if (~WB_DAT_I[`RTCC_WREN_BIT])
          wren_ff <= 1'b0;
        else if (UNLOCK)
          wren_ff <= 1'b1;
      end
    end
  end

  // Rollover ripples one field per cycle
  always @*
  begin
    nxt_state = state_ff;
    nxt_sec = sec_ff;
    nxt_min = min_ff;
    nxt_hour = hour_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (sec_pulse)
        begin
          nxt_sec = wrap_inc(sec_ff, `RTCC_SEC_MAX);
          if (sec_ff >= `RTCC_SEC_MAX)
            nxt_state = ST_MIN;
        end
      end
      ST_MIN:
      begin
        nxt_min = wrap_inc(min_ff, `RTCC_MIN_MAX);
        nxt_state = (min_ff >= `RTCC_MIN_MAX) ? ST_HOUR : ST_IDLE;
      end
      ST_HOUR:
      begin
        nxt_hour = wrap_inc(hour_ff, `RTCC_HOUR_MAX);
        nxt_state = ST_IDLE;
      end
      default:
        nxt_state = ST_IDLE;
    endcase
    if (wr_time)
    begin
      if (WB_SEL_I[1])
        nxt_sec = WB_DAT_I[`RTCC_SEC_MSB:`RTCC_SEC_LSB];
      if (WB_SEL_I[2])
        nxt_min = WB_DAT_I[`RTCC_MIN_MSB:`RTCC_MIN_LSB];
      if (WB_SEL_I[3])
        nxt_hour = WB_DAT_I[`RTCC_HOUR_MSB:`RTCC_HOUR_LSB];
    end
  end

  always @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      state_ff <= ST_IDLE;
      sec_ff <= 7'h00;
      min_ff <= 7'h00;
      hour_ff <= 7'h00;
      sync_ff <= 1'b0;
      out_ff <= 1'b0;
      out_oe_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      sec_ff <= nxt_sec;
      min_ff <= nxt_min;
      hour_ff <= nxt_hour;
      // Covers the window before the tick and the carry chain
      sync_ff <= near_roll | sec_pulse | (nxt_state != ST_IDLE);
      out_ff <= oe_ff & on_ff & phase;
      out_oe_ff <= oe_ff;
    end
  end

  assign WB_ACK_O = ack_ff;
  assign WB_DAT_O = dat_ff;
  assign RTCC_OUT = out_ff;
  assign RTCC_OUT_OE = out_oe_ff;
endmodule

// File: hw/rtcc_regs.vh
`ifndef RTCC_REGS_VH
`define RTCC_REGS_VH

// Register byte addresses
`define RTCC_CTRL_ADDR 4'h0
`define RTCC_TIME_ADDR 4'h4

// Control register fields
`define RTCC_ON_BIT 15
`define RTCC_WREN_BIT 3
`define RTCC_SYNC_BIT 2
`define RTCC_HALF_BIT 1
`define RTCC_OE_BIT 0
`define RTCC_CTRL_RST 32'h00000000

// Time register fields
`define RTCC_SEC_LSB 8
`define RTCC_SEC_MSB 14
`define RTCC_MIN_LSB 16
`define RTCC_MIN_MSB 22
`define RTCC_HOUR_LSB 24
`define RTCC_HOUR_MSB 30
`define RTCC_TIME_RST 32'h00000000
`define RTCC_SEC_MAX 7'h3B
`define RTCC_MIN_MAX 7'h3B
`define RTCC_HOUR_MAX 7'h17

// Timing
`define RTCC_CLK_PERIOD_NS 32'd5
`define RTCC_HALF_SEC_MS 32'd500
`define RTCC_HALF_SEC_CYC ((`RTCC_HALF_SEC_MS * 32'd1000000) / `RTCC_CLK_PERIOD_NS)
`define RTCC_RIPPLE_NS 32'd160
`define RTCC_RIPPLE_CYC ((`RTCC_RIPPLE_NS + `RTCC_CLK_PERIOD_NS - 32'd1) / `RTCC_CLK_PERIOD_NS)

`endif

// File: hw/rtcc_tick.v
`timescale 1ns/1ps
`include "rtcc_regs.vh"

module rtcc_tick #(
  parameter [31:0] HALF_CYC = `RTCC_HALF_SEC_CYC
)
(
  input wire clk,
  input wire rst,
  input wire run,
  input wire restart,
  output wire phase,
  output wire sec_pulse,
  output wire near_roll
);
  localparam [31:0] WIN_CYC = `RTCC_RIPPLE_CYC;
  reg [31:0] cnt_ff;
  reg phase_ff;
  reg sec_ff;
  reg near_ff;
  wire last = (cnt_ff == HALF_CYC - 32'd1);

  always @(posedge clk)
  begin
    if (rst)
    begin
      cnt_ff <= 32'h00000000;
      phase_ff <= 1'b0;
      sec_ff <= 1'b0;
      near_ff <= 1'b0;
    end
    else
    begin
      sec_ff <= 1'b0;
      if (restart)
      begin
        // Seconds write restarts the second at its first half
        cnt_ff <= 32'h00000000;
        phase_ff <= 1'b0;
      end
      else if (run)
      begin
        if (last)
        begin
          cnt_ff <= 32'h00000000;
          phase_ff <= ~phase_ff;
          sec_ff <= phase_ff;
        end
        else
          cnt_ff <= cnt_ff + 32'd1;
      end
      near_ff <= run & phase_ff & (cnt_ff + WIN_CYC >= HALF_CYC);
    end
  end

  assign phase = phase_ff;
  assign sec_pulse = sec_ff;
  assign near_roll = near_ff;
endmodule

// File: tb/rtcc_ctrl_asserts.sv
`timescale 1ns/1ps
module rtcc_ctrl_asserts #(
  parameter [31:0] HALF_SEC_CYC = 32'd64
)
(
  input wire CORE_CLK,
  input wire SYS_RST,
  input wire WARM_RST,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [3:0] WB_ADR_I,
  input wire [31:0] WB_DAT_O,
  input wire WB_ACK_O,
  input wire RTCC_OUT,
  input wire RTCC_OUT_OE
);
  wire rq = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  wire rd_ctl = rq && !WB_WE_I && WB_ADR_I == 4'h0;
  default clocking dc @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  property p_ack_rsp; rq && !WARM_RST |=> WB_ACK_O; endproperty
  a_ack_rsp: assert property (p_ack_rsp) else $error("ack missing");
  property p_ack_one; WB_ACK_O |=> !WB_ACK_O; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_ack_src; WB_ACK_O |-> $past(rq); endproperty
  a_ack_src: assert property (p_ack_src) else $error("ack without request");
  property p_oe_out; !RTCC_OUT_OE |-> !RTCC_OUT; endproperty
  a_oe_out: assert property (p_oe_out) else $error("output while disabled");
  property p_oe_rd; rd_ctl |=> WB_DAT_O[0] == RTCC_OUT_OE; endproperty
  a_oe_rd: assert property (p_oe_rd) else $error("enable bit and pin differ");
  property p_unmap;
    rq && !WB_WE_I && WB_ADR_I != 4'h0 && WB_ADR_I != 4'h4 |=> WB_DAT_O == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_rsv; rd_ctl |=> WB_DAT_O[31:16] == 16'h0 && WB_DAT_O[14:4] == 11'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_warm;
    WARM_RST && !WB_CYC_I && !$past(WB_CYC_I) |=> $stable(RTCC_OUT_OE);
  endproperty
  a_warm: assert property (p_warm) else $error("warm reset hit control");
  property p_rst; $fell(SYS_RST) |-> !WB_ACK_O && !RTCC_OUT_OE && WB_DAT_O == 32'h0; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  cover property (rq && WB_WE_I);
  cover property ($rose(RTCC_OUT));
  cover property (WARM_RST);
endmodule
bind rtcc_ctrl rtcc_ctrl_asserts #(.HALF_SEC_CYC(HALF_SEC_CYC)) rtcc_ctrl_asserts_i (
  .CORE_CLK(CORE_CLK),
  .SYS_RST(SYS_RST),
  .WARM_RST(WARM_RST),
  .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I),
  .WB_ADR_I(WB_ADR_I),
  .WB_DAT_O(WB_DAT_O),
  .WB_ACK_O(WB_ACK_O),
  .RTCC_OUT(RTCC_OUT),
  .RTCC_OUT_OE(RTCC_OUT_OE)
);

// File: tb/rtcc_ctrl_tb.sv
`timescale 1ns/1ps
module rtcc_ctrl_tb;
  logic clk = 0, rst = 1, warm = 0, unl = 0, cyc = 0, stb = 0, we = 0;
  logic [3:0] adr = 4'h0, sel = 4'hF;
  logic [31:0] dat = 32'h0, dato, rd;
  logic ack, out, oe;
  int bad_count = 0, n_compared = 0;
  always #2.5 clk = ~clk;
  rtcc_ctrl #(.HALF_SEC_CYC(32'd64)) rtcc_ctrl_i (.CORE_CLK(clk), .SYS_RST(rst),
    .WARM_RST(warm), .UNLOCK(unl), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dato),
    .WB_ACK_O(ack), .RTCC_OUT(out), .RTCC_OUT_OE(oe));
  task tally_and_finish;
    begin
      if (bad_count == 0 && n_compared > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    begin
      n_compared++;
      if (s !== e)
      begin
        bad_count++;
        $display("[ERR] %0t seen %h want %h", $time, s, e);
      end
    end
  endtask
  // One classic cycle, byte lanes as currently set in sel
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    begin
      @(posedge clk);
      {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
      n = 0;
      do
      begin
        @(posedge clk);
        n++;
      end
      while (ack !== 1'b1 && n < 20);
      {cyc, stb} <= 2'b00;
      rd = dato;
      if (n >= 20)
      begin
        bad_count++;
        tally_and_finish;
      end
    end
  endtask
  task s_lock;
    begin
      wb(1'b1, 4'h8, 32'hFFFFFFFF);
      wb(1'b0, 4'h8, 32'h0);
      chk(rd, 32'h0);
      wb(1'b1, 4'h0, 32'h8009);
      wb(1'b0, 4'h0, 32'h0);
      chk(rd & 32'h8009, 32'h1);
      wb(1'b1, 4'h4, 32'h1500);
      wb(1'b0, 4'h4, 32'h0);
      chk(rd, 32'h0);
      unl <= 1'b1;
      wb(1'b1, 4'h0, 32'h8009);
      wb(1'b0, 4'h0, 32'h0);
      chk(rd & 32'h8009, 32'h9);
      wb(1'b1, 4'h0, 32'h8009);
      unl <= 1'b0;
      wb(1'b1, 4'h4, 32'h1500);
      wb(1'b0, 4'h4, 32'h0);
      chk(rd, 32'h1500);
    end
  endtask
  // Phase restarts at the seconds write; half is 64 cycles
  task s_half;
    begin
      repeat (70) @(posedge clk);
      wb(1'b0, 4'h0, 32'h0);
      chk(rd & 32'h6, 32'h2);
      chk({31'h0, out}, 32'h1);
      repeat (25) @(posedge clk);
      wb(1'b0, 4'h0, 32'h0);
      chk(rd & 32'h6, 32'h6);
      wb(1'b0, 4'h4, 32'h0);
      chk(rd, 32'h1500);
      wb(1'b0, 4'h4, 32'h0);
      chk(rd, 32'h1500);
      // Minute-only write must leave the half-second phase alone
      sel <= 4'h4;
      wb(1'b1, 4'h4, 32'h00050000);
      sel <= 4'hF;
      wb(1'b0, 4'h0, 32'h0);
      chk(rd & 32'h2, 32'h2);
      wb(1'b1, 4'h4, 32'h2000);
      wb(1'b0, 4'h0, 32'h0);
      chk(rd & 32'h2, 32'h0);
    end
  endtask
  task s_oe;
    begin
      wb(1'b1, 4'h0, 32'h8008);
      repeat (2) @(posedge clk);
      chk({30'h0, oe, out}, 32'h0);
    end
  endtask
  task s_rst;
    begin
      warm <= 1'b1;
      @(posedge clk);
      warm <= 1'b0;
      wb(1'b0, 4'h0, 32'h0);
      chk(rd & 32'h8009, 32'h8008);
      wb(1'b1, 4'h0, 32'h0008);
      @(posedge clk);
      wb(1'b0, 4'h0, 32'h0);
      chk(rd & 32'h8009, 32'h8);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      wb(1'b0, 4'h0, 32'h0);
      chk(rd, 32'h0);
    end
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    s_lock;
    s_half;
    s_oe;
    s_rst;
    tally_and_finish;
  end
endmodule
